// ===== src/event_sleep_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

module event_sleep_ctrl
    import misc_sys_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_nrst,
    input  wire logic i_wfe_go,
    input  wire logic i_wfi_go,
    input  wire logic i_sev_local,
    input  wire logic i_ext_event,
    input  wire logic i_asleep,
    input  wire logic i_exc_unmasked,
    input  wire logic i_exc_new_pend,
    input  wire logic i_wake_on_pending,
    input  wire logic i_debug_req,
    input  wire logic i_debug_en,
    input  wire logic i_irq_taken,
    input  wire logic i_irq_pend_imask,
    output logic      o_event,
    output logic      o_wfe_sleeps,
    output logic      o_wake
);
    logic event_q;
    logic event_d;
    logic wfe_mode_q;
    logic wfe_wake;
    logic wfi_wake;

    // ----------------------------------------
    // event register
    // ----------------------------------------
    // a set in the consume cycle wins so no event is lost
    assign event_d = (i_sev_local | i_ext_event) | (event_q & ~i_wfe_go);

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            event_q <= EVENT_RST;
        else
            event_q <= event_d;
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            wfe_mode_q <= 1'b0;
        else if (i_wfe_go | i_wfi_go)
            wfe_mode_q <= i_wfe_go;
    end

    // ----------------------------------------
    // wake conditions
    // ----------------------------------------
    assign wfe_wake = i_exc_unmasked | (i_exc_new_pend & i_wake_on_pending)
                    | (i_debug_req & i_debug_en) | i_ext_event;
    assign wfi_wake = i_irq_taken | i_irq_pend_imask | i_debug_req;

    assign o_event      = event_q;
    assign o_wfe_sleeps = ~event_q;
    assign o_wake       = i_asleep & (wfe_mode_q ? wfe_wake : wfi_wake);

endmodule : event_sleep_ctrl
`default_nettype wire

// ===== src/misc_sys_pkg.sv
package misc_sys_pkg;

    // ----------------------------------------
    // instruction classes
    // ----------------------------------------
    typedef enum logic [3:0] {
        OP_NOP  = 4'h0,
        OP_BREAKPOINT_INSTR = 4'h1,
        OP_CPS  = 4'h2,
        OP_DMB  = 4'h3,
        OP_DSB  = 4'h4,
        OP_ISB  = 4'h5,
        OP_MRS  = 4'h6,
        OP_MSR  = 4'h7,
        OP_SEV  = 4'h8,
        OP_SVC  = 4'h9,
        OP_WFE  = 4'hA,
        OP_WFI  = 4'hB,
        OP_IT   = 4'hC
    } op_type;

    // ----------------------------------------
    // special register selectors
    // ----------------------------------------
    typedef enum logic [3:0] {
        SR_APPLICATION_STATUS_FLAGS  = 4'h0, SR_IAPSR = 4'h1, SR_EAPSR = 4'h2,
        SR_PSR   = 4'h3, SR_EXCEPTION_NUMBER_FIELD  = 4'h4, SR_EXECUTION_STATE_FIELD  = 4'h5,
        SR_IEPSR = 4'h6, SR_MSP   = 4'h7, SR_PSP   = 4'h8,
        SR_IMASK = 4'h9, SR_BPRI  = 4'hA, SR_BPMAX = 4'hB,
        SR_FMASK = 4'hC, SR_CTRL  = 4'hD
    } sreg_type;

    // ----------------------------------------
    // sequencer states
    // ----------------------------------------
    typedef enum logic [4:0] {
        ST_RUN   = 5'h01,
        ST_DRAIN = 5'h02,
        ST_FLUSH = 5'h04,
        ST_SLEEP = 5'h08,
        ST_HALT  = 5'h10
    } state_type;

    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int          FLAGS_LO      = 27;
    localparam int          FLAGS_HI      = 31;
    localparam int          BPRI_W        = 8;
    localparam logic [4:0]  FLAGS_RST     = 5'h00;
    localparam logic [7:0]  BPRI_RST      = 8'h00;
    localparam logic [1:0]  CTRL_RST      = 2'h0;
    localparam logic [31:0] SP_RST        = 32'h00000000;
    localparam logic [7:0]  IT_RST        = 8'h00;
    localparam logic        EVENT_RST     = 1'b0;

endpackage : misc_sys_pkg

// ===== src/misc_system_instruction_unit.sv
`timescale 1ns/100ps
`default_nettype none

module misc_system_instruction_unit
    import misc_sys_pkg::*;
(
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_nrst,
    input  wire logic                   i_instr_valid,
    input  wire misc_sys_pkg::op_type   i_op,
    input  wire misc_sys_pkg::sreg_type i_sreg_sel,
    input  wire logic [31:0]            i_wdata,
    input  wire logic                   i_priv,
    input  wire logic                   i_cps_disable,
    input  wire logic                   i_cps_i,
    input  wire logic                   i_cps_f,
    input  wire logic [3:0]             i_it_cond,
    input  wire logic [3:0]             i_it_mask,
    input  wire logic                   i_mem_busy,
    input  wire logic                   i_ext_event,
    input  wire logic                   i_exc_unmasked,
    input  wire logic                   i_exc_new_pend,
    input  wire logic                   i_wake_on_pending,
    input  wire logic                   i_debug_req,
    input  wire logic                   i_debug_en,
    input  wire logic                   i_debug_resume,
    input  wire logic                   i_irq_taken,
    input  wire logic                   i_irq_pend_imask,
    output logic                        o_instr_ready,
    output logic                        o_executed,
    output logic [31:0]                 o_rdata,
    output logic                        o_rdata_valid,
    output logic                        o_mem_order_hold,
    output logic                        o_pipe_flush,
    output logic                        o_debug_halt,
    output logic                        o_halted,
    output logic                        o_svc_req,
    output logic                        o_sev_out,
    output logic                        o_sleeping,
    output logic                        o_event,
    output logic                        o_in_it_block,
    output logic [4:0]                  o_flags,
    output logic                        o_int_mask,
    output logic                        o_fault_mask,
    output logic [7:0]                  o_base_priority_mask,
    output logic [1:0]                  o_control
);

    // ----------------------------------------
    // condition check against n z c v
    // ----------------------------------------
    function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
        logic n;
        logic z;
        logic cy;
        logic v;
        logic r;
        n  = f[3];
        z  = f[2];
        cy = f[1];
        v  = f[0];
        case (c[3:1])
            3'h0:    r = z;
            3'h1:    r = cy;
            3'h2:    r = n;
            3'h3:    r = v;
            3'h4:    r = cy & ~z;
            3'h5:    r = (n == v);
            3'h6:    r = (n == v) & ~z;
            default: r = 1'b1;
        endcase
        // odd codes invert, except the always code
        if (c[0] && (c != 4'hF))
            r = ~r;
        return r;
    endfunction : cond_ok

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    state_type   state_q;
    state_type   state_d;
    logic [7:0]  it_q;
    logic [7:0]  it_d;
    logic [7:0]  it_next;
    logic        hold_q;
    logic        hold_d;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic        rvalid_q;
    logic        flush_q;
    logic        breakpoint_instr_q;
    logic        svc_q;
    logic        sev_q;
    logic        exec_q;
    logic [31:0] msp;
    logic [31:0] psp;
    logic        wfe_sleeps;
    logic        wake;

    wire         accept;
    wire         in_it;
    wire         pass;
    wire         run;
    wire         is_breakpoint_instr;
    wire         do_breakpoint_instr;
    wire         do_cps;
    wire         do_dmb;
    wire         do_dsb;
    wire         do_isb;
    wire         do_mrs;
    wire         do_msr;
    wire         do_sev;
    wire         do_svc;
    wire         do_wfe;
    wire         do_wfi;
    wire         do_it;
    wire         wfe_sleep;
    wire [31:0]  flag_word;

    // ----------------------------------------
    // issue and condition decode
    // ----------------------------------------
    // only the run state takes instructions; all stalls live here
    assign o_instr_ready = (state_q == ST_RUN);
    assign accept        = i_instr_valid & o_instr_ready;
    assign in_it         = (it_q[3:0] != 4'h0);
    assign pass          = ~in_it | cond_ok(it_q[7:4], o_flags[4:1]);
    assign is_breakpoint_instr       = (i_op == OP_BREAKPOINT_INSTR);
    assign run           = accept & (pass | is_breakpoint_instr);

    assign do_breakpoint_instr   = run & is_breakpoint_instr;
    assign do_cps    = run & (i_op == OP_CPS);
    assign do_dmb    = run & (i_op == OP_DMB);
    assign do_dsb    = run & (i_op == OP_DSB);
    assign do_isb    = run & (i_op == OP_ISB);
    assign do_mrs    = run & (i_op == OP_MRS);
    assign do_msr    = run & (i_op == OP_MSR);
    assign do_sev    = run & (i_op == OP_SEV);
    assign do_svc    = run & (i_op == OP_SVC);
    assign do_wfe    = run & (i_op == OP_WFE);
    assign do_wfi    = run & (i_op == OP_WFI);
    // a nested if-then is not allowed; it is treated as a no-op
    assign do_it     = run & (i_op == OP_IT) & ~in_it;
    assign wfe_sleep = do_wfe & wfe_sleeps;

    // ----------------------------------------
    // if-then tracking
    // ----------------------------------------
    // top three condition bits stay, the low five bits shift one slot per instruction
    assign it_next = (it_q[2:0] == 3'h0) ? IT_RST : {it_q[7:5], it_q[3:0], 1'b0};

    assign it_d = (accept & in_it) ? it_next :
                  do_it            ? {i_it_cond, i_it_mask} :
                                     it_q;

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            it_q <= IT_RST;
        else
            it_q <= it_d;
    end

    // ----------------------------------------
    // barrier tracking
    // ----------------------------------------
    // the load/store unit must hold new accesses while this is high,
    // other instructions keep flowing
    assign hold_d = (do_dmb & i_mem_busy) | (hold_q & i_mem_busy);

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            hold_q <= 1'b0;
        else
            hold_q <= hold_d;
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN:
            begin
                if (do_dsb)
                    state_d = ST_DRAIN;
                else if (do_isb)
                    state_d = ST_FLUSH;
                else if (do_breakpoint_instr)
                    state_d = ST_HALT;
                else if (do_wfi | wfe_sleep)
                    state_d = ST_SLEEP;
            end
            ST_DRAIN:
            begin
                if (!i_mem_busy)
                    state_d = ST_RUN;
            end
            ST_FLUSH:
            begin
                state_d = ST_RUN;
            end
            ST_SLEEP:
            begin
                if (wake)
                    state_d = ST_RUN;
            end
            ST_HALT:
            begin
                if (i_debug_resume)
                    state_d = ST_RUN;
            end
            default:
            begin
                state_d = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            state_q <= ST_RUN;
        else
            state_q <= state_d;
    end

    // ----------------------------------------
    // special register read
    // ----------------------------------------
    // status views carry flags only; execution and exception fields are zero
    assign flag_word = {o_flags, 27'h0000000};

    always_comb
    begin
        rdata_d = 32'h00000000;
        unique case (i_sreg_sel)
            SR_APPLICATION_STATUS_FLAGS, SR_IAPSR, SR_EAPSR, SR_PSR:
                rdata_d = flag_word;
            SR_EXCEPTION_NUMBER_FIELD, SR_EXECUTION_STATE_FIELD, SR_IEPSR:
                rdata_d = 32'h00000000;
            SR_MSP:
                rdata_d = msp;
            SR_PSP:
                rdata_d = psp;
            SR_IMASK:
                rdata_d = {31'h00000000, o_int_mask};
            SR_BPRI, SR_BPMAX:
                rdata_d = {24'h000000, o_base_priority_mask};
            SR_FMASK:
                rdata_d = {31'h00000000, o_fault_mask};
            SR_CTRL:
                rdata_d = {30'h00000000, o_control};
            default:
                rdata_d = 32'h00000000;
        endcase
    end

    // ----------------------------------------
    // result and pulse registers
    // ----------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rdata_q  <= 32'h00000000;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= do_mrs;
            if (do_mrs)
                rdata_q <= rdata_d;
        end
    end

    // nop needs no state: it retires like any other accepted instruction not skipped in an if-then block
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            flush_q <= 1'b0;
            breakpoint_instr_q  <= 1'b0;
            svc_q   <= 1'b0;
            sev_q   <= 1'b0;
            exec_q  <= 1'b0;
        end
        else
        begin
            flush_q <= do_isb;
            breakpoint_instr_q  <= do_breakpoint_instr;
            svc_q   <= do_svc;
            sev_q   <= do_sev;
            exec_q  <= run;
        end
    end

    // ----------------------------------------
    // special registers
    // ----------------------------------------
    special_reg_file u_regs (
        .i_clk_sys     (i_clk_sys),
        .i_nrst        (i_nrst),
        .i_wr_en       (do_msr),
        .i_sel         (i_sreg_sel),
        .i_wdata       (i_wdata),
        .i_priv        (i_priv),
        .i_cps_en      (do_cps),
        .i_cps_disable (i_cps_disable),
        .i_cps_i       (i_cps_i),
        .i_cps_f       (i_cps_f),
        .o_flags       (o_flags),
        .o_int_mask    (o_int_mask),
        .o_fault_mask  (o_fault_mask),
        .o_base_priority_mask     (o_base_priority_mask),
        .o_control     (o_control),
        .o_msp         (msp),
        .o_psp         (psp)
    );

    // ----------------------------------------
    // event register and wake logic
    // ----------------------------------------
    event_sleep_ctrl u_sleep (
        .i_clk_sys         (i_clk_sys),
        .i_nrst            (i_nrst),
        .i_wfe_go          (do_wfe),
        .i_wfi_go          (do_wfi),
        .i_sev_local       (do_sev),
        .i_ext_event       (i_ext_event),
        .i_asleep          (state_q == ST_SLEEP),
        .i_exc_unmasked    (i_exc_unmasked),
        .i_exc_new_pend    (i_exc_new_pend),
        .i_wake_on_pending (i_wake_on_pending),
        .i_debug_req       (i_debug_req),
        .i_debug_en        (i_debug_en),
        .i_irq_taken       (i_irq_taken),
        .i_irq_pend_imask  (i_irq_pend_imask),
        .o_event           (o_event),
        .o_wfe_sleeps      (wfe_sleeps),
        .o_wake            (wake)
    );

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_executed       = exec_q;
    assign o_rdata          = rdata_q;
    assign o_rdata_valid    = rvalid_q;
    assign o_mem_order_hold = hold_q;
    assign o_pipe_flush     = flush_q;
    assign o_debug_halt     = breakpoint_instr_q;
    assign o_halted         = (state_q == ST_HALT);
    assign o_svc_req        = svc_q;
    assign o_sev_out        = sev_q;
    assign o_sleeping       = (state_q == ST_SLEEP);
    assign o_in_it_block    = in_it;

endmodule : misc_system_instruction_unit
`default_nettype wire

// ===== src/special_reg_file.sv
`timescale 1ns/100ps
`default_nettype none

module special_reg_file
    import misc_sys_pkg::*;
(
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_nrst,
    input  wire logic                 i_wr_en,
    input  wire misc_sys_pkg::sreg_type i_sel,
    input  wire logic [31:0]          i_wdata,
    input  wire logic                 i_priv,
    input  wire logic                 i_cps_en,
    input  wire logic                 i_cps_disable,
    input  wire logic                 i_cps_i,
    input  wire logic                 i_cps_f,
    output logic [4:0]                o_flags,
    output logic                      o_int_mask,
    output logic                      o_fault_mask,
    output logic [7:0]                o_base_priority_mask,
    output logic [1:0]                o_control,
    output logic [31:0]               o_msp,
    output logic [31:0]               o_psp
);
    logic       sel_flags;
    logic       wr_flags;
    logic       wr_priv;
    logic       bpmax_ok;
    logic [7:0] new_bp;

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    // exception_number_field/execution_state_field/iepsr never reach a field: those bits are not stored
    assign sel_flags = (i_sel == SR_APPLICATION_STATUS_FLAGS) | (i_sel == SR_IAPSR)
                     | (i_sel == SR_EAPSR) | (i_sel == SR_PSR);
    assign wr_flags  = i_wr_en & sel_flags;
    assign wr_priv   = i_wr_en & i_priv;
    assign new_bp    = i_wdata[BPRI_W-1:0];
    assign bpmax_ok  = (new_bp != 8'h00)
                     & ((o_base_priority_mask == 8'h00) | (new_bp < o_base_priority_mask));

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_flags      <= FLAGS_RST;
            o_int_mask   <= 1'b0;
            o_fault_mask <= 1'b0;
            o_base_priority_mask    <= BPRI_RST;
            o_control    <= CTRL_RST;
            o_msp        <= SP_RST;
            o_psp        <= SP_RST;
        end
        else
        begin
            if (wr_flags)
                o_flags <= i_wdata[FLAGS_HI:FLAGS_LO];
            if (i_cps_en & i_priv & i_cps_i)
                o_int_mask <= i_cps_disable;
            else if (wr_priv & (i_sel == SR_IMASK))
                o_int_mask <= i_wdata[0];
            if (i_cps_en & i_priv & i_cps_f)
                o_fault_mask <= i_cps_disable;
            else if (wr_priv & (i_sel == SR_FMASK))
                o_fault_mask <= i_wdata[0];
            if (wr_priv & ((i_sel == SR_BPRI) | ((i_sel == SR_BPMAX) & bpmax_ok)))
                o_base_priority_mask <= new_bp;
            if (wr_priv & (i_sel == SR_CTRL))
                o_control <= i_wdata[1:0];
            if (wr_priv & (i_sel == SR_MSP))
                o_msp <= {i_wdata[31:2], 2'b00};
            if (wr_priv & (i_sel == SR_PSP))
                o_psp <= {i_wdata[31:2], 2'b00};
        end
    end

endmodule : special_reg_file
`default_nettype wire

// ===== verification/mem_side_model.sv
`timescale 1ns/100ps
`default_nettype none
// memory side: earlier accesses stay outstanding five cycles after a start
module mem_side_model (
    input  wire logic i_clk_sys,
    input  wire logic i_nrst,
    input  wire logic i_start,
    output logic      o_busy
);
    logic [3:0] cnt_q;
    always_ff @(posedge i_clk_sys or negedge i_nrst)
        if (!i_nrst) cnt_q <= 4'h0;
        else if (i_start) cnt_q <= 4'h5;
        else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    assign o_busy = (cnt_q != 4'h0);
endmodule : mem_side_model
`default_nettype wire

// ===== verification/misc_sys_sva.sv
`timescale 1ns/100ps
`default_nettype none
module misc_sys_sva
    import misc_sys_pkg::*;
(
    input wire logic                  i_clk_sys,
    input wire logic                  i_nrst,
    input wire logic                  i_instr_valid,
    input wire misc_sys_pkg::op_type  i_op,
    input wire logic                  i_priv,
    input wire logic                  i_ext_event,
    input wire logic                  i_mem_busy,
    input wire logic                  o_instr_ready,
    input wire logic                  o_in_it_block,
    input wire logic                  o_sev_out,
    input wire logic                  o_event,
    input wire logic                  o_debug_halt,
    input wire logic                  o_halted,
    input wire logic                  o_svc_req,
    input wire logic                  o_sleeping,
    input wire logic                  o_pipe_flush,
    input wire logic                  o_mem_order_hold,
    input wire logic                  o_int_mask,
    input wire logic                  o_fault_mask
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    // ----
    // taken outside an if-then block
    // ----
    sequence s_take(op_type op);
        i_instr_valid && o_instr_ready && i_op == op && !o_in_it_block;
    endsequence
    a_breakpoint_instr_halts: assert property (i_instr_valid && o_instr_ready && i_op == OP_BREAKPOINT_INSTR
        |=> o_debug_halt && o_halted) else $error("breakpoint did not halt");
    a_cps_unpriv: assert property (s_take(OP_CPS) ##0 !i_priv
        |=> $stable(o_int_mask) && $stable(o_fault_mask)) else $error("mask changed");
    a_dmb_holds: assert property (s_take(OP_DMB) ##0 i_mem_busy
        |=> o_mem_order_hold && o_instr_ready) else $error("order barrier wrong");
    a_dsb_stalls: assert property (s_take(OP_DSB) |=> !o_instr_ready)
        else $error("sync barrier did not stall");
    a_drain_ends: assert property (!o_instr_ready && !o_sleeping && !o_halted
        && !i_mem_busy |=> o_instr_ready) else $error("stall outlived memory");
    a_isb_flush: assert property (s_take(OP_ISB)
        |=> o_pipe_flush && !o_instr_ready ##1 o_instr_ready) else $error("flush wrong");
    a_sev_event: assert property (s_take(OP_SEV) |=> o_sev_out && o_event)
        else $error("event broadcast missing");
    a_svc_trap: assert property (s_take(OP_SVC) |=> o_svc_req)
        else $error("service trap missing");
    a_wfe_sleeps: assert property (s_take(OP_WFE) ##0 !o_event && !i_ext_event
        |=> o_sleeping) else $error("wait event did not sleep");
    a_wfe_passes: assert property (s_take(OP_WFE) ##0 o_event && !i_ext_event
        |=> !o_event && o_instr_ready) else $error("wait event did not pass");
    a_wfi_sleeps: assert property (s_take(OP_WFI) |=> o_sleeping)
        else $error("wait interrupt did not sleep");
endmodule : misc_sys_sva
bind misc_system_instruction_unit misc_sys_sva u_sva (.*);
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import misc_sys_pkg::*;
    typedef struct {op_type op; sreg_type s; logic [31:0] w; logic p;
        logic [4:0] fl; logic [7:0] bp; logic [31:0] rd;} row_type;
    logic i_clk_sys = 1'b0, i_nrst = 1'b0, i_instr_valid = 1'b0, i_priv = 1'b1;
    logic i_cps_disable = 1'b0, i_cps_i = 1'b0, i_cps_f = 1'b0, mem_start = 1'b0;
    logic i_exc_unmasked = 1'b0, i_wake_on_pending = 1'b1, i_debug_en = 1'b0;
    logic i_debug_resume = 1'b0, i_irq_taken = 1'b0;
    logic i_mem_busy, i_ext_event, i_exc_new_pend, i_debug_req, i_irq_pend_imask;
    logic [3:0] i_it_cond = 4'h0, i_it_mask = 4'h0, wake = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    op_type i_op = OP_NOP;
    sreg_type i_sreg_sel = SR_APPLICATION_STATUS_FLAGS;
    logic o_instr_ready, o_executed, o_rdata_valid, o_mem_order_hold, o_pipe_flush;
    logic o_debug_halt, o_halted, o_svc_req, o_sev_out, o_sleeping, o_event;
    logic o_in_it_block, o_int_mask, o_fault_mask;
    logic [31:0] o_rdata;
    logic [4:0] o_flags;
    logic [7:0] o_base_priority_mask;
    logic [1:0] o_control;
    int n_mismatch = 0, check_count = 0;
    row_type rows [11] = '{
        '{OP_MSR, SR_APPLICATION_STATUS_FLAGS, 32'hF8000000, 1'b0, 5'h1F, 8'h00, 32'h0},
        '{OP_MRS, SR_PSR, 32'h0, 1'b0, 5'h1F, 8'h00, 32'hF8000000},
        '{OP_MSR, SR_PSR, 32'h080001FF, 1'b0, 5'h01, 8'h00, 32'h0},
        '{OP_MSR, SR_BPRI, 32'h40, 1'b0, 5'h01, 8'h00, 32'h0},
        '{OP_MSR, SR_BPRI, 32'h40, 1'b1, 5'h01, 8'h40, 32'h0},
        '{OP_MSR, SR_BPMAX, 32'h0, 1'b1, 5'h01, 8'h40, 32'h0},
        '{OP_MSR, SR_BPMAX, 32'h60, 1'b1, 5'h01, 8'h40, 32'h0},
        '{OP_MSR, SR_BPMAX, 32'h20, 1'b1, 5'h01, 8'h20, 32'h0},
        '{OP_MRS, SR_BPMAX, 32'h0, 1'b1, 5'h01, 8'h20, 32'h20},
        '{OP_MSR, SR_EXCEPTION_NUMBER_FIELD, 32'hFFFFFFFF, 1'b1, 5'h01, 8'h20, 32'h0},
        '{OP_MRS, SR_PSR, 32'h0, 1'b1, 5'h01, 8'h20, 32'h08000000}};
    logic [5:0] cps_tab [3] = '{6'h3F, 6'h0F, 6'h26};
    assign {i_debug_req, i_irq_pend_imask, i_ext_event, i_exc_new_pend} = wake;
    misc_system_instruction_unit dut (.*);
    mem_side_model u_mem (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_start(mem_start),
        .o_busy(i_mem_busy));
    always #5 i_clk_sys = ~i_clk_sys;
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // one instruction; returns in the cycle after it is taken
    task automatic issue(op_type op, sreg_type s = SR_APPLICATION_STATUS_FLAGS, logic [31:0] w = 32'h0);
        @(negedge i_clk_sys);
        while (o_instr_ready !== 1'b1) @(negedge i_clk_sys);
        i_instr_valid = 1'b1;
        i_op = op;
        i_sreg_sel = s;
        i_wdata = w;
        @(negedge i_clk_sys);
        i_instr_valid = 1'b0;
    endtask : issue
    task automatic end_of_test();
        if (n_mismatch == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    initial
    begin
        #20us;
        n_mismatch++;
        end_of_test();
    end
    initial
    begin
        repeat (3) @(negedge i_clk_sys);
        i_nrst = 1'b1;
        chk("event", 0, o_event);
        foreach (rows[k])
        begin
            i_priv = rows[k].p;
            issue(rows[k].op, rows[k].s, rows[k].w);
            chk("flags", rows[k].fl, o_flags);
            chk("base_priority_mask", rows[k].bp, o_base_priority_mask);
            if (rows[k].op == OP_MRS) chk("rdata", rows[k].rd, o_rdata);
            chk("rdata valid", rows[k].op == OP_MRS, o_rdata_valid);
        end
        foreach (cps_tab[k])
        begin
            {i_priv, i_cps_disable, i_cps_i, i_cps_f} = cps_tab[k][5:2];
            issue(OP_CPS);
            chk("masks", cps_tab[k][1:0], {o_int_mask, o_fault_mask});
        end
        issue(OP_NOP);
        chk("nop ready", 1, o_instr_ready);
        chk("nop retired", 1, o_executed);
        issue(OP_SEV);
        chk("sev", 2'h3, {o_sev_out, o_event});
        issue(OP_WFE);
        chk("wfe pass", 2'h1, {o_event, o_instr_ready});
        mem_start = 1'b1;
        @(negedge i_clk_sys);
        mem_start = 1'b0;
        issue(OP_DMB);
        chk("hold", 2'h3, {o_mem_order_hold, o_instr_ready});
        issue(OP_DSB);
        chk("stall", 2'h1, {o_instr_ready, i_mem_busy});
        while (i_mem_busy) @(negedge i_clk_sys);
        @(negedge i_clk_sys);
        chk("drained", 1, o_instr_ready);
        issue(OP_ISB);
        chk("flush", 2'h2, {o_pipe_flush, o_instr_ready});
        issue(OP_SVC);
        chk("trap", 1, o_svc_req);
        // new pending and external event (wfe), masked irq and debug request (wfi) in turn; the external event sets the event register
        for (int k = 0; k < 4; k++)
        begin
            issue(k < 2 ? OP_WFE : OP_WFI);
            @(negedge i_clk_sys);
            chk("asleep", 2'h2, {o_sleeping, o_instr_ready});
            wake = 4'h1 << k;
            @(negedge i_clk_sys);
            wake = 4'h0;
            @(negedge i_clk_sys);
            chk("woken", 1, o_instr_ready);
        end
        i_it_mask = 4'h4;
        issue(OP_IT);
        chk("in block", 1, o_in_it_block);
        issue(OP_SVC);
        chk("skipped trap", 0, o_svc_req);
        chk("skipped exec", 0, o_executed);
        issue(OP_BREAKPOINT_INSTR);
        chk("halt", 2'h3, {o_debug_halt, o_halted});
        i_debug_resume = 1'b1;
        @(negedge i_clk_sys);
        i_debug_resume = 1'b0;
        @(negedge i_clk_sys);
        chk("resumed", 1, o_instr_ready);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
